/* File: hw/ctbc_pkg.sv */
// package: offsets, field positions and codings for the temperature band config
`default_nettype none
package ctbc_pkg;
    // register addresses on the host register port
    localparam logic [7:0] ADDR_CHARGE_END_WARM = 8'h03;
    localparam logic [7:0] ADDR_COOL_NORMAL     = 8'h04;
    localparam logic [7:0] ADDR_WARM_HOT        = 8'h05;
    localparam logic [7:0] ADDR_ACCESS_ENABLE   = 8'h11;
    localparam int         ACCESS_ENABLE_BIT    = 0;
    // field positions
    localparam int EOC_MSB = 7;
    localparam int EOC_LSB = 6;
    localparam int VWARM_MSB = 5;
    localparam int VWARM_LSB = 3;
    localparam int VHOT_MSB = 2;
    localparam int VHOT_LSB = 0;
    localparam int NIB_HI_MSB = 7;
    localparam int NIB_HI_LSB = 4;
    localparam int NIB_LO_MSB = 3;
    localparam int NIB_LO_LSB = 0;
    // reset values (not printed; plain zero)
    localparam logic [7:0] RESET_CONFIG = 8'h00;
    // current step and base, milliamps
    localparam logic [11:0] CURRENT_STEP_MA = 12'h064;
    localparam logic [11:0] CURRENT_BASE_MA = 12'h000;
    // end-of-charge currents in milliamps
    localparam logic [11:0] EOC_MA_0 = 12'h032;
    localparam logic [11:0] EOC_MA_1 = 12'h064;
    localparam logic [11:0] EOC_MA_2 = 12'h0B9;
    localparam logic [11:0] EOC_MA_3 = 12'h172;
    // termination voltages in millivolts
    localparam logic [12:0] VT_MV_0 = 13'h0F64;
    localparam logic [12:0] VT_MV_1 = 13'h0FA0;
    localparam logic [12:0] VT_MV_2 = 13'h0FD2;
    localparam logic [12:0] VT_MV_3 = 13'h1004;
    localparam logic [12:0] VT_MV_4 = 13'h1018;
    localparam logic [12:0] VT_MV_5 = 13'h1036;
    localparam logic [12:0] VT_MV_6 = 13'h1054;
    localparam logic [2:0]  VT_INVALID_CODE = 3'h7;

    // battery temperature band, one-hot
    typedef enum logic [5:0] {
        BAND_BELOW   = 6'h01,
        BAND_COLD    = 6'h02,
        BAND_NORMAL  = 6'h04,
        BAND_WARM    = 6'h08,
        BAND_HOT     = 6'h10,
        BAND_ABOVE   = 6'h20
    } ctbc_band_type;

    // host register access request
    typedef struct packed {
        logic       write;
        logic       read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ctbc_req_type;

    // settings handed to the charge loop
    typedef struct packed {
        logic [11:0] maxCurrentMa;
        logic [12:0] termVoltageMv;
        logic        chargeEnable;
        logic        tempFault;
        logic        vtermInvalid;
    } ctbc_setting_type;
endpackage
`default_nettype wire

/* File: hw/ctbc_regs.sv */
// temperature band charge configuration registers and band setting select
`default_nettype none
module ctbc_regs (
    input  wire logic                       ref_clk,
    input  wire logic                       rst,
    input  wire ctbc_pkg::ctbc_req_type     hostReq,
    output var  logic [7:0]                 hostRdata,
    output var  logic                       hostAck,
    input  wire ctbc_pkg::ctbc_band_type    tempBand,
    input  wire logic [12:0]                coldNormalVtermMv,
    input  wire logic                       outputBelowPrecharge,
    output var  ctbc_pkg::ctbc_setting_type chargeSetting
);
    logic [7:0] chargeEndWarm;
    logic [7:0] coolNormal;
    logic [7:0] warmHot;
    logic       accessEnable;
    logic [7:0] next_chargeEndWarm;
    logic [7:0] next_coolNormal;
    logic [7:0] next_warmHot;
    logic       next_accessEnable;
    logic [7:0] next_hostRdata;
    logic       next_hostAck;
    ctbc_pkg::ctbc_setting_type next_chargeSetting;
    logic [3:0] bandNibble;
    logic [2:0] bandVcode;
    logic [11:0] eocMa;
    logic [11:0] bandMa;

    // voltage code to millivolts
    function automatic logic [12:0] vtermDecode(input logic [2:0] code);
        logic [12:0] mv;
        mv = ctbc_pkg::VT_MV_0;
        unique case (code)
            3'h0: mv = ctbc_pkg::VT_MV_0;
            3'h1: mv = ctbc_pkg::VT_MV_1;
            3'h2: mv = ctbc_pkg::VT_MV_2;
            3'h3: mv = ctbc_pkg::VT_MV_3;
            3'h4: mv = ctbc_pkg::VT_MV_4;
            3'h5: mv = ctbc_pkg::VT_MV_5;
            3'h6: mv = ctbc_pkg::VT_MV_6;
            // invalid code: hold lowest voltage, safest for the cell
            3'h7: mv = ctbc_pkg::VT_MV_0;
        endcase
        return mv;
    endfunction

    // register file next values and read data
    always_comb
    begin
        next_chargeEndWarm = chargeEndWarm;
        next_coolNormal = coolNormal;
        next_warmHot = warmHot;
        next_accessEnable = accessEnable;
        next_hostRdata = hostRdata;
        next_hostAck = 1'b0;
        if (hostReq.write || hostReq.read)
        begin
            next_hostAck = 1'b1;
            next_hostRdata = 8'h00;
        end
        if (hostReq.addr == ctbc_pkg::ADDR_ACCESS_ENABLE)
        begin
            if (hostReq.write)
            begin
                next_accessEnable =
                    hostReq.wdata[ctbc_pkg::ACCESS_ENABLE_BIT];
            end
            if (hostReq.read)
            begin
                next_hostRdata = {7'h00, accessEnable};
            end
        end
        else if (accessEnable)
        begin
            unique case (hostReq.addr)
                ctbc_pkg::ADDR_CHARGE_END_WARM:
                begin
                    if (hostReq.write)
                        next_chargeEndWarm = hostReq.wdata;
                    if (hostReq.read)
                        next_hostRdata = chargeEndWarm;
                end
                ctbc_pkg::ADDR_COOL_NORMAL:
                begin
                    if (hostReq.write)
                        next_coolNormal = hostReq.wdata;
                    if (hostReq.read)
                        next_hostRdata = coolNormal;
                end
                ctbc_pkg::ADDR_WARM_HOT:
                begin
                    if (hostReq.write)
                        next_warmHot = hostReq.wdata;
                    if (hostReq.read)
                        next_hostRdata = warmHot;
                end
                default:
                begin
                    next_hostRdata = (hostReq.write || hostReq.read)
                        ? 8'h00 : hostRdata;
                end
            endcase
        end
    end

    // register file flops
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            chargeEndWarm <= ctbc_pkg::RESET_CONFIG;
            coolNormal <= ctbc_pkg::RESET_CONFIG;
            warmHot <= ctbc_pkg::RESET_CONFIG;
            accessEnable <= 1'b0;
            hostRdata <= 8'h00;
            hostAck <= 1'b0;
        end
        else
        begin
            chargeEndWarm <= next_chargeEndWarm;
            coolNormal <= next_coolNormal;
            warmHot <= next_warmHot;
            accessEnable <= next_accessEnable;
            hostRdata <= next_hostRdata;
            hostAck <= next_hostAck;
        end
    end

    // band selection and decode of the charge setting
    always_comb
    begin
        bandNibble = 4'h0;
        bandVcode = 3'h0;
        eocMa = ctbc_pkg::EOC_MA_0;
        next_chargeSetting = '0;
        unique case (chargeEndWarm[ctbc_pkg::EOC_MSB:ctbc_pkg::EOC_LSB])
            2'h0: eocMa = ctbc_pkg::EOC_MA_0;
            2'h1: eocMa = ctbc_pkg::EOC_MA_1;
            2'h2: eocMa = ctbc_pkg::EOC_MA_2;
            2'h3: eocMa = ctbc_pkg::EOC_MA_3;
        endcase
        unique case (tempBand)
            ctbc_pkg::BAND_COLD:
                bandNibble = coolNormal[ctbc_pkg::NIB_HI_MSB:
                                        ctbc_pkg::NIB_HI_LSB];
            ctbc_pkg::BAND_NORMAL:
                bandNibble = coolNormal[ctbc_pkg::NIB_LO_MSB:
                                        ctbc_pkg::NIB_LO_LSB];
            ctbc_pkg::BAND_WARM:
            begin
                bandNibble = warmHot[ctbc_pkg::NIB_HI_MSB:
                                     ctbc_pkg::NIB_HI_LSB];
                bandVcode = chargeEndWarm[ctbc_pkg::VWARM_MSB:
                                          ctbc_pkg::VWARM_LSB];
            end
            ctbc_pkg::BAND_HOT:
            begin
                bandNibble = warmHot[ctbc_pkg::NIB_LO_MSB:
                                     ctbc_pkg::NIB_LO_LSB];
                bandVcode = chargeEndWarm[ctbc_pkg::VHOT_MSB:
                                          ctbc_pkg::VHOT_LSB];
            end
            default:
                bandNibble = 4'h0;
        endcase
        // linear 100 mA steps, code n is n times 100 mA
        bandMa = ctbc_pkg::CURRENT_BASE_MA
            + 12'(bandNibble * ctbc_pkg::CURRENT_STEP_MA);
        // precharge limit while output is low
        next_chargeSetting.maxCurrentMa =
            outputBelowPrecharge ? eocMa : bandMa;
        if (tempBand == ctbc_pkg::BAND_WARM || tempBand == ctbc_pkg::BAND_HOT)
        begin
            next_chargeSetting.termVoltageMv = vtermDecode(bandVcode);
            next_chargeSetting.vtermInvalid =
                (bandVcode == ctbc_pkg::VT_INVALID_CODE);
        end
        else
            next_chargeSetting.termVoltageMv = coldNormalVtermMv;
        next_chargeSetting.tempFault = (tempBand == ctbc_pkg::BAND_BELOW)
            || (tempBand == ctbc_pkg::BAND_ABOVE);
        next_chargeSetting.chargeEnable = !next_chargeSetting.tempFault
            && !next_chargeSetting.vtermInvalid;
    end

    // setting output register
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            chargeSetting <= '0;
        else
            chargeSetting <= next_chargeSetting;
    end

    out_of_band_a: assert property (@(posedge ref_clk) disable iff (rst)
        (tempBand == ctbc_pkg::BAND_ABOVE) |=>
        (chargeSetting.tempFault && !chargeSetting.chargeEnable))
        else $error("charging not stopped out of band");
    // blocked write leaves every config register alone
    gated_write_a: assert property (@(posedge ref_clk) disable iff (rst)
        (!accessEnable && hostReq.write) |=>
        ($stable(chargeEndWarm) && $stable(coolNormal) && $stable(warmHot)))
        else $error("write passed while access disabled");
    gated_read_a: assert property (@(posedge ref_clk) disable iff (rst)
        (!accessEnable && hostReq.read
         && hostReq.addr == ctbc_pkg::ADDR_CHARGE_END_WARM) |=>
        (hostRdata == 8'h00))
        else $error("config read passed while access disabled");
    read_back_a: assert property (@(posedge ref_clk) disable iff (rst)
        (accessEnable && hostReq.read
         && hostReq.addr == ctbc_pkg::ADDR_COOL_NORMAL) |=>
        (hostRdata == $past(coolNormal)))
        else $error("read data differs from register");
    ack_pulse_a: assert property (@(posedge ref_clk) disable iff (rst)
        (hostReq.write || hostReq.read) |=> hostAck)
        else $error("access not acknowledged");
    // cold band current in 100 mA steps
    cold_band_a: assert property (@(posedge ref_clk) disable iff (rst)
        (tempBand == ctbc_pkg::BAND_COLD && !outputBelowPrecharge) |=>
        (chargeSetting.maxCurrentMa
            == {8'h00, $past(coolNormal[7:4])} * ctbc_pkg::CURRENT_STEP_MA))
        else $error("cold band current wrong");
    eoc_limit_a: assert property (@(posedge ref_clk) disable iff (rst)
        (outputBelowPrecharge && chargeEndWarm[7:6] == 2'h3) |=>
        (chargeSetting.maxCurrentMa == ctbc_pkg::EOC_MA_3))
        else $error("end-of-charge limit not applied");
endmodule
`default_nettype wire

/* File: sim/ctbc_host_model.sv */
// host side model: issues single-byte register accesses
`default_nettype none
module ctbc_host_model (
    input  wire logic                   ref_clk,
    input  wire logic                   hostAck,
    output var  ctbc_pkg::ctbc_req_type hostReq
);
    timeunit 1ns;
    timeprecision 1ps;

    initial hostReq = '0;

    // one access per request cycle, bounded wait for the ack
    task automatic access(input  logic       wr,
                          input  logic [7:0] a,
                          input  logic [7:0] d,
                          output logic       ok);
        int n;
        n = 0;
        @(posedge ref_clk);
        hostReq <= '{write: wr, read: !wr, addr: a, wdata: d};
        @(posedge ref_clk);
        // idle bus shows garbage, so a design that samples late is caught
        hostReq <= '{write: 1'b0, read: 1'b0, addr: ~a, wdata: ~d};
        #1;
        while (hostAck !== 1'b1 && n < 8)
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        ok = (hostAck === 1'b1);
    endtask
endmodule
`default_nettype wire

/* File: sim/test_ctbc_regs.sv */
// self-checking bench for the temperature band configuration registers
`default_nettype none
module test_ctbc_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic                       ref_clk = 1'b0;
    logic                       rst = 1'b1;
    ctbc_pkg::ctbc_req_type     hostReq;
    logic [7:0]                 hostRdata;
    logic                       hostAck;
    ctbc_pkg::ctbc_band_type    tempBand = ctbc_pkg::BAND_NORMAL;
    logic [12:0]                coldNormalVtermMv = 13'h1004;
    logic                       outputBelowPrecharge = 1'b0;
    ctbc_pkg::ctbc_setting_type chargeSetting;
    logic [8:0]                 noteQ[$];
    logic [8:0]                 note;
    logic [31:0]                seed = 32'h3841;
    logic                       preSel = 1'b0;
    logic [1:0]                 eocSel = 2'h0;
    int                         bad_count = 0;
    int                         samples_checked = 0;
    logic [11:0] eocTab[4] = '{ctbc_pkg::EOC_MA_0, ctbc_pkg::EOC_MA_1,
                               ctbc_pkg::EOC_MA_2, ctbc_pkg::EOC_MA_3};
    logic [12:0] vtTab[8] = '{ctbc_pkg::VT_MV_0, ctbc_pkg::VT_MV_1,
                              ctbc_pkg::VT_MV_2, ctbc_pkg::VT_MV_3,
                              ctbc_pkg::VT_MV_4, ctbc_pkg::VT_MV_5,
                              ctbc_pkg::VT_MV_6, ctbc_pkg::VT_MV_0};

    always #12.5 ref_clk = ~ref_clk;

    ctbc_regs ctbc_regs_i (
        .ref_clk              (ref_clk),
        .rst                  (rst),
        .hostReq              (hostReq),
        .hostRdata            (hostRdata),
        .hostAck              (hostAck),
        .tempBand             (tempBand),
        .coldNormalVtermMv    (coldNormalVtermMv),
        .outputBelowPrecharge (outputBelowPrecharge),
        .chargeSetting        (chargeSetting)
    );

    ctbc_host_model ctbc_host_model_i (
        .ref_clk (ref_clk),
        .hostAck (hostAck),
        .hostReq (hostReq)
    );

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // expected setting; invalid code falls back to lowest voltage
    function automatic ctbc_pkg::ctbc_setting_type ex(
        input logic [3:0] n, input logic [12:0] v, input logic inv);
        ctbc_pkg::ctbc_setting_type e;
        e.maxCurrentMa = preSel ? eocTab[eocSel]
                       : {8'h00, n} * ctbc_pkg::CURRENT_STEP_MA;
        e.termVoltageMv = inv ? vtTab[0] : v;
        e.chargeEnable = !inv;
        e.tempFault = 1'b0;
        e.vtermInvalid = inv;
        return e;
    endfunction

    task automatic fail(input string msg);
        bad_count++;
        $display("FAIL %0t %s", $time, msg);
    endtask

    task automatic close_out;
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // oldest note against each acknowledged access
    always @(posedge ref_clk)
    begin
        if (hostAck === 1'b1)
        begin
            samples_checked++;
            if (noteQ.size() == 0)
                fail("ack without access");
            else
            begin
                note = noteQ.pop_front();
                if (note[8] && hostRdata !== note[7:0])
                    fail("read data");
            end
        end
    end

    task automatic regAcc(input logic wr, input logic [7:0] a,
                          input logic [7:0] d, input logic [7:0] e);
        logic ok;
        noteQ.push_back({~wr, e});
        ctbc_host_model_i.access(wr, a, d, ok);
        if (!ok)
        begin
            fail("no ack");
            close_out();
        end
    endtask

    // setting lands one cycle after the band input; masked compare
    task automatic checkSet(input ctbc_pkg::ctbc_band_type b,
                            input ctbc_pkg::ctbc_setting_type e,
                            input logic [27:0] m);
        @(posedge ref_clk);
        tempBand <= b;
        repeat (2) @(posedge ref_clk);
        #1;
        samples_checked++;
        if ((chargeSetting & m) !== (e & m))
            fail("charge setting");
    endtask

    initial
    begin
        int i;
        logic [7:0] r04;
        logic [7:0] r05;
        logic [12:0] cn;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        regAcc(1'b1, 8'h03, 8'hA5, 8'h00);
        regAcc(1'b0, 8'h03, 8'h00, 8'h00);
        regAcc(1'b1, 8'h11, 8'h01, 8'h00);
        regAcc(1'b0, 8'h03, 8'h00, 8'h00);
        regAcc(1'b0, 8'h07, 8'h00, 8'h00);
        for (i = 0; i < 6; i++)
        begin
            seed = xs(seed);
            regAcc(1'b1, 8'(3 + i % 3), seed[7:0], 8'h00);
            regAcc(1'b0, 8'(3 + i % 3), 8'h00, seed[7:0]);
        end
        for (i = 0; i < 8; i++)
        begin
            seed = xs(seed);
            r04 = seed[7:0];
            r05 = seed[15:8];
            cn = seed[28:16];
            regAcc(1'b1, 8'h03, {i[1:0], i[2:0], 3'(7 - i)}, 8'h00);
            regAcc(1'b1, 8'h04, r04, 8'h00);
            regAcc(1'b1, 8'h05, r05, 8'h00);
            @(posedge ref_clk);
            preSel = i[2];
            eocSel = i[1:0];
            outputBelowPrecharge <= i[2];
            coldNormalVtermMv <= cn;
            checkSet(ctbc_pkg::BAND_COLD, ex(r04[7:4], cn, 1'b0), '1);
            checkSet(ctbc_pkg::BAND_NORMAL, ex(r04[3:0], cn, 1'b0), '1);
            checkSet(ctbc_pkg::BAND_WARM, ex(r05[7:4], vtTab[i], i == 7),
                     '1);
            checkSet(ctbc_pkg::BAND_HOT, ex(r05[3:0], vtTab[7 - i], i == 0),
                     '1);
            checkSet(ctbc_pkg::BAND_BELOW, 28'h0000002, 28'h0000006);
            checkSet(ctbc_pkg::BAND_ABOVE, 28'h0000002, 28'h0000006);
        end
        close_out();
    end
endmodule
`default_nettype wire
